// ===== rtl/hbi_dev.sv
/*
 * Device end of the host port: register access, event causes, interrupt and master clock.
 * Assumes the processor strobes are asynchronous and held for several clocks.
 */
`timescale 1ns/10ps
`include "hbi_map.svh"
module hbi_dev
	import hbi_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Processor pins
	hbi_if.dev bus,
	// Line side
	input wire logic hook_switch_in,
	// Status to the rest of the chip
	output logic active_mode,
	output logic [7:0] ctrl_out
);

	hbi_dev_st_t q;
	hbi_dev_st_t n;
	logic [5:0] mclk_cnt_ff = 6'h00;
	logic mclk_ff = 1'b0;
	logic [5:0] half_per;
	logic rd_now;
	logic rd_was;
	logic wr_now;
	logic wr_was;
	logic hook_chg;
	logic frame_tick;
	logic [7:0] rd_val;
	logic [7:0] clr;
	logic [7:0] set;

	// Divider table
	always_comb begin
		case (q.ctrl[`HBI_CTRL_SEL_HI:`HBI_CTRL_SEL_LO])
			3'h0: half_per = `HBI_MCLK_HP0;
			3'h1: half_per = `HBI_MCLK_HP1;
			3'h2: half_per = `HBI_MCLK_HP2;
			3'h3: half_per = `HBI_MCLK_HP3;
			3'h4: half_per = `HBI_MCLK_HP4;
			3'h5: half_per = `HBI_MCLK_HP5;
			default: half_per = `HBI_MCLK_HP6;
		endcase
	end

	// Free running divider, untouched by reset
	always_ff @(posedge clk) begin
		if (mclk_cnt_ff + 6'h01 >= half_per) begin
			mclk_cnt_ff <= 6'h00;
			mclk_ff <= ~mclk_ff;
		end else begin
			mclk_cnt_ff <= mclk_cnt_ff + 6'h01;
		end
	end

	// Register read mux
	always_comb begin
		case (q.sel_s2)
			`HBI_REG_CAUSE: rd_val = q.cause;
			`HBI_REG_MASK: rd_val = q.mask;
			`HBI_REG_CTRL: rd_val = q.ctrl;
			`HBI_REG_STAT: begin
				rd_val = 8'h00;
				rd_val[`HBI_STAT_HOOK] = q.hook_s2;
				rd_val[`HBI_STAT_MODE] = q.mode;
				rd_val[`HBI_STAT_INT] = ~q.int_n;
			end
			`HBI_REG_BPTR: rd_val = {4'h0, q.bptr};
			`HBI_REG_BDATA: rd_val = q.mem[q.bptr];
			default: rd_val = 8'h00;
		endcase
	end

	// Next state
	always_comb begin
		n = q;
		// Two flop synchronisers on every pin
		n.ctl_s1 = {~bus.cs_n, ~bus.rd_n, ~bus.wr_n};
		n.ctl_s2 = q.ctl_s1;
		n.ctl_q = q.ctl_s2;
		n.sel_s1 = bus.reg_select;
		n.sel_s2 = q.sel_s1;
		n.dat_s1 = bus.d_bus;
		n.dat_s2 = q.dat_s1;
		n.hook_s1 = hook_switch_in;
		n.hook_s2 = q.hook_s1;
		n.hook_q = q.hook_s2;

		// Strobes count only while selected
		rd_now = q.ctl_s2[2] & q.ctl_s2[1];
		rd_was = q.ctl_q[2] & q.ctl_q[1];
		wr_now = q.ctl_s2[2] & q.ctl_s2[0];
		wr_was = q.ctl_q[2] & q.ctl_q[0];
		hook_chg = q.hook_s2 ^ q.hook_q;
		frame_tick = (q.frame_cnt == 12'(`HBI_FRAME_CYC - 1));
		clr = 8'h00;
		set = 8'h00;

		// Frame counter
		n.frame_cnt = frame_tick ? 12'h000 : q.frame_cnt + 12'h001;

		// Read: capture on falling strobe, drive while held
		n.doe = rd_now;
		if (rd_now && !rd_was) begin
			n.dout = rd_val;
			n.rd_snap = (q.sel_s2 == `HBI_REG_CAUSE) ? q.cause : 8'h00;
		end
		if (!rd_now && rd_was) begin
			if (q.sel_s2 == `HBI_REG_CAUSE) begin
				clr = q.rd_snap;
			end
			if (q.sel_s2 == `HBI_REG_BDATA) begin
				n.bptr = q.bptr + 4'h1;
			end
		end

		// Write: capture on rising strobe
		if (!wr_now && wr_was) begin
			case (q.sel_s2)
				`HBI_REG_MASK: n.mask = q.dat_s2;
				`HBI_REG_CTRL: n.ctrl = q.dat_s2;
				`HBI_REG_BPTR: n.bptr = q.dat_s2[3:0];
				`HBI_REG_BDATA: begin
					n.mem[q.bptr] = q.dat_s2;
					n.bptr = q.bptr + 4'h1;
				end
				default: ;
			endcase
		end

		// Operating mode follows control
		case (q.mode)
			1'(HBI_IDLE): begin
				if (q.ctrl[`HBI_CTRL_ACT]) begin
					n.mode = 1'(HBI_ACTIVE);
					set[`HBI_CAUSE_ACT] = 1'b1;
				end
			end
			1'(HBI_ACTIVE): begin
				if (!q.ctrl[`HBI_CTRL_ACT]) begin
					n.mode = 1'(HBI_IDLE);
				end
			end
			default: n.mode = 1'(HBI_IDLE);
		endcase

		// Causes: a new event wins over a clear
		if (hook_chg) begin
			set[`HBI_CAUSE_HOOK] = 1'b1;
		end
		n.cause = (q.cause & ~clr) | set;

		// Interrupt line
		if (|clr) begin
			n.int_n = 1'b1;
		end else if (frame_tick) begin
			n.int_n = q.int_n & ~|(q.cause & q.mask);
		end
	end

	// State register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q <= '0;
			q.mask <= `HBI_MASK_RST;
			q.ctrl <= `HBI_CTRL_RST;
			q.mode <= 1'(HBI_IDLE);
			q.int_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// Outputs
	assign bus.d_dev = q.dout;
	assign bus.d_dev_oe = q.doe;
	assign bus.int_n = q.int_n;
	assign bus.mclk = mclk_ff;
	assign active_mode = q.mode;
	assign ctrl_out = q.ctrl;

endmodule : hbi_dev

// ===== rtl/hbi_host.sv
/*
 * Processor end of the host port: turns user requests into strobed bus cycles.
 * Assumes the device synchronises strobes and needs them held several clocks.
 */
`timescale 1ns/10ps
`include "hbi_map.svh"
module hbi_host
	import hbi_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// User requests
	input wire logic req,
	input wire logic req_write,
	input wire logic [2:0] req_addr,
	input wire logic [7:0] req_wdata,
	// User answers
	output logic busy,
	output logic done,
	output logic [7:0] rdata,
	output logic irq,
	// Device pins
	hbi_if.host bus
);

	hbi_host_st_t q;
	hbi_host_st_t n;

	always_comb begin
		n = q;
		n.din_s1 = bus.d_bus;
		n.din_s2 = q.din_s1;
		n.int_s1 = bus.int_n;
		n.int_s2 = q.int_s1;
		n.irq = ~q.int_s2;
		n.done = 1'b0;
		case (hbi_hstate_t'(q.state))
			HBI_H_IDLE: begin
				if (req) begin
					n.write = req_write;
					n.sel = req_addr;
					n.dout = req_wdata;
					n.busy = 1'b1;
					n.cs_n = 1'b0;
					n.doe = req_write;
					n.cnt = 4'h0;
					n.state = 2'(HBI_H_SETUP);
				end
			end
			HBI_H_SETUP: begin
				n.rd_n = q.write;
				n.wr_n = ~q.write;
				n.state = 2'(HBI_H_STROBE);
			end
			HBI_H_STROBE: begin
				n.cnt = q.cnt + 4'h1;
				if (q.cnt == `HBI_STROBE_CYC - 4'h1) begin
					n.rd_n = 1'b1;
					n.wr_n = 1'b1;
					if (!q.write) begin
						n.rdata = q.din_s2;
					end
					n.cnt = 4'h0;
					n.state = 2'(HBI_H_HOLD);
				end
			end
			HBI_H_HOLD: begin
				n.cnt = q.cnt + 4'h1;
				if (q.cnt == `HBI_HOLD_CYC - 4'h1) begin
					n.cs_n = 1'b1;
					n.doe = 1'b0;
					n.busy = 1'b0;
					n.done = 1'b1;
					n.state = 2'(HBI_H_IDLE);
				end
			end
			default: n.state = 2'(HBI_H_IDLE);
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			q <= '0;
			q.cs_n <= 1'b1;
			q.rd_n <= 1'b1;
			q.wr_n <= 1'b1;
			q.int_s1 <= 1'b1;
			q.int_s2 <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign busy = q.busy;
	assign done = q.done;
	assign rdata = q.rdata;
	assign irq = q.irq;
	assign bus.cs_n = q.cs_n;
	assign bus.rd_n = q.rd_n;
	assign bus.wr_n = q.wr_n;
	assign bus.reg_select = q.sel;
	assign bus.d_host = q.dout;
	assign bus.d_host_oe = q.doe;

endmodule : hbi_host

// ===== rtl/hbi_if.sv
/*
 * Pins between the processor and the device port.
 * Assumes each end drives its data only with its enable; an idle bus reads high.
 */
`timescale 1ns/10ps
interface hbi_if;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic [2:0] reg_select;
	logic [7:0] d_host;
	logic d_host_oe;
	logic [7:0] d_dev;
	logic d_dev_oe;
	logic [7:0] d_bus;
	logic int_n;
	logic mclk;

	// Resolved data lines, pulled up when nobody drives
	assign d_bus = d_dev_oe ? d_dev : (d_host_oe ? d_host : 8'hff);

	modport dev (input cs_n, input rd_n, input wr_n, input reg_select, input d_bus,
		output d_dev, output d_dev_oe, output int_n, output mclk);
	modport host (output cs_n, output rd_n, output wr_n, output reg_select,
		output d_host, output d_host_oe, input d_bus, input int_n, input mclk);
endinterface : hbi_if

// ===== rtl/hbi_map.svh
/*
 * Register map, field positions, reset values and timing counts of the host port.
 * Assumes a 25 MHz system clock shared by both ends.
 */
`ifndef HBI_MAP_SVH
`define HBI_MAP_SVH

// Clock and frame timing
`define HBI_CLK_MHZ 25
`define HBI_FRAME_NS 125000
`define HBI_FRAME_CYC ((`HBI_FRAME_NS * `HBI_CLK_MHZ) / 1000)

// Register selects
`define HBI_REG_CAUSE 3'h0
`define HBI_REG_MASK 3'h1
`define HBI_REG_CTRL 3'h2
`define HBI_REG_STAT 3'h3
`define HBI_REG_BPTR 3'h4
`define HBI_REG_BDATA 3'h5

// Cause bits
`define HBI_CAUSE_HOOK 0
`define HBI_CAUSE_ACT 1

// Control fields
`define HBI_CTRL_ACT 0
`define HBI_CTRL_SEL_LO 1
`define HBI_CTRL_SEL_HI 3

// Status fields
`define HBI_STAT_HOOK 0
`define HBI_STAT_MODE 1
`define HBI_STAT_INT 2

// Reset values
`define HBI_MASK_RST 8'h03
`define HBI_CTRL_RST 8'h00

// Master clock half periods per divider select
`define HBI_MCLK_HP0 6'h01
`define HBI_MCLK_HP1 6'h02
`define HBI_MCLK_HP2 6'h03
`define HBI_MCLK_HP3 6'h04
`define HBI_MCLK_HP4 6'h08
`define HBI_MCLK_HP5 6'h10
`define HBI_MCLK_HP6 6'h20

// Host strobe timing in cycles
`define HBI_STROBE_CYC 4'h8
`define HBI_HOLD_CYC 4'h3

`endif

// ===== rtl/hbi_pkg.sv
/*
 * Types of the host port: modes, host states and the state records of both ends.
 * Assumes hbi_map.svh for all numeric constants.
 */
package hbi_pkg;
	typedef enum {HBI_IDLE, HBI_ACTIVE} hbi_mode_t;
	typedef enum {HBI_H_IDLE, HBI_H_SETUP, HBI_H_STROBE, HBI_H_HOLD} hbi_hstate_t;

	typedef struct packed {
		logic [2:0] ctl_s1;
		logic [2:0] ctl_s2;
		logic [2:0] ctl_q;
		logic [2:0] sel_s1;
		logic [2:0] sel_s2;
		logic [7:0] dat_s1;
		logic [7:0] dat_s2;
		logic hook_s1;
		logic hook_s2;
		logic hook_q;
		logic [11:0] frame_cnt;
		logic [7:0] cause;
		logic [7:0] rd_snap;
		logic [7:0] mask;
		logic [7:0] ctrl;
		logic [3:0] bptr;
		logic [15:0][7:0] mem;
		logic mode;
		logic [7:0] dout;
		logic doe;
		logic int_n;
	} hbi_dev_st_t;

	typedef struct packed {
		logic [1:0] state;
		logic [3:0] cnt;
		logic write;
		logic [2:0] sel;
		logic [7:0] dout;
		logic doe;
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [7:0] din_s1;
		logic [7:0] din_s2;
		logic int_s1;
		logic int_s2;
		logic irq;
		logic busy;
		logic done;
		logic [7:0] rdata;
	} hbi_host_st_t;
endpackage : hbi_pkg

// ===== verification/hbi_monitor.sv
/* Assertions on the host port pins.
 * Assumes the bench instantiates it beside the interface. */
`timescale 1ns/10ps
`include "hbi_map.svh"
module hbi_monitor (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Pins
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic [2:0] reg_select,
	input wire logic d_host_oe,
	input wire logic d_dev_oe,
	input wire logic int_n,
	input wire logic mclk
);
	logic [11:0] ph_ff;
	logic [11:0] tick_ff;
	logic seen_ff;
	logic m_ff = 1'b0;
	logic [7:0] still_ff = 8'h00;
	// Frame phase
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ph_ff <= 12'h000;
			tick_ff <= 12'h000;
			seen_ff <= 1'b0;
		end else begin
			ph_ff <= (ph_ff == `HBI_FRAME_CYC - 1) ? 12'h000 : ph_ff + 12'h001;
			if ($fell(int_n)) begin
				seen_ff <= 1'b1;
				tick_ff <= ph_ff;
			end
		end
	end
	// Cycles since mclk last moved
	always_ff @(posedge clk) begin
		m_ff <= mclk;
		still_ff <= (mclk != m_ff) ? 8'h00 : still_ff + 8'h01;
	end
	oe_rise_a: assert property (@(posedge clk) disable iff (reset)
		$rose(d_dev_oe) |-> !cs_n && !rd_n) else $error("data driven without read");
	no_clash_a: assert property (@(posedge clk) disable iff (reset)
		!(d_dev_oe && d_host_oe)) else $error("both ends drive data");
	oe_release_a: assert property (@(posedge clk) disable iff (reset)
		rd_n [*6] |-> !d_dev_oe) else $error("data not released");
	rd_resp_a: assert property (@(posedge clk) disable iff (reset)
		$fell(rd_n) && !cs_n |-> ##[2:5] d_dev_oe) else $error("no read data");
	wr_hold_a: assert property (@(posedge clk) disable iff (reset)
		$rose(wr_n) |-> d_host_oe && !cs_n) else $error("write data gone");
	strobe_sel_a: assert property (@(posedge clk) disable iff (reset)
		!rd_n || !wr_n |-> !cs_n) else $error("strobe without select");
	int_frame_a: assert property (@(posedge clk) disable iff (reset)
		$fell(int_n) && seen_ff |-> ph_ff == tick_ff) else $error("interrupt off frame");
	int_hold_a: assert property (@(posedge clk) disable iff (reset)
		$rose(int_n) |-> $past(reg_select, 3) == `HBI_REG_CAUSE) else $error("int dropped");
	mclk_run_a: assert property (@(posedge clk)
		still_ff < 8'h28) else $error("mclk stalled");
endmodule : hbi_monitor

// ===== verification/test_host_bus_interface.sv
/* Bench joining host and device ends of the host port.
 * Assumes hbi_map.svh and the package are compiled first. */
`timescale 1ns/10ps
`include "hbi_map.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module test_host_bus_interface;
	import hbi_pkg::*;
	logic clk = 0;
	logic reset = 1;
	logic req = 0;
	logic req_write = 0;
	logic hook = 0;
	logic [2:0] req_addr = 3'h0;
	logic [7:0] req_wdata = 8'h00;
	logic busy, done, irq, active_mode;
	logic [7:0] rdata, ctrl_out, rd;
	logic [7:0] q[4];
	logic [31:0] seed = 32'hf712;
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int n;
	hbi_if bus();
	hbi_host u_hbi_host (.clk(clk), .reset(reset), .req(req), .req_write(req_write),
		.req_addr(req_addr), .req_wdata(req_wdata), .busy(busy), .done(done),
		.rdata(rdata), .irq(irq), .bus(bus));
	hbi_dev u_hbi_dev (.clk(clk), .reset(reset), .bus(bus), .hook_switch_in(hook),
		.active_mode(active_mode), .ctrl_out(ctrl_out));
	hbi_monitor u_hbi_monitor (.clk(clk), .reset(reset), .cs_n(bus.cs_n), .rd_n(bus.rd_n),
		.wr_n(bus.wr_n), .reg_select(bus.reg_select), .d_host_oe(bus.d_host_oe),
		.d_dev_oe(bus.d_dev_oe), .int_n(bus.int_n), .mclk(bus.mclk));
	always #20 clk = ~clk;
	function automatic logic [7:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : xs
	function automatic int hp(input int s);
		int t[7] = '{1, 2, 3, 4, 8, 16, 32};
		return t[s];
	endfunction : hp
	task automatic wt(input logic [7:0] s, input int lim);
		n = 0;
		while ((s === 8'h00 ? irq !== 1'b1 : bus.mclk === rd[0]) && n < lim) begin
			@(posedge clk);
			#2;
			n++;
		end
	endtask : wt
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		#2;
		req = 1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(posedge clk);
		#2;
		req = 0;
		`CHK(busy, 1'b1)
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(posedge clk);
			#2;
			n++;
		end
		`CHK(n < 40, 1'b1)
		`CHK(busy, 1'b0)
		`CHK(bus.cs_n, 1'b1)
		rd = rdata;
	endtask : acc
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			end_of_test();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		#2;
		reset = 0;
		`CHK(active_mode, 1'b0)
		acc(0, `HBI_REG_MASK, 8'h00);
		`CHK(rd, `HBI_MASK_RST)
		acc(1, `HBI_REG_BPTR, 8'h00);
		foreach (q[i]) begin
			q[i] = (i == 0) ? 8'h01 : xs();
			acc(1, `HBI_REG_BDATA, q[i]);
		end
		acc(1, `HBI_REG_BPTR, 8'h00);
		foreach (q[i]) begin
			acc(0, `HBI_REG_BDATA, 8'h00);
			`CHK(rd, q[i])
		end
		$display("buffer test done");
		for (int s = 0; s < 7; s++) begin
			acc(1, `HBI_REG_CTRL, 8'(s << 1));
			`CHK(ctrl_out, 8'(s << 1))
			rd[0] = bus.mclk;
			wt(8'h01, 99);
			rd[0] = bus.mclk;
			wt(8'h01, 99);
			`CHK(n, hp(s))
		end
		$display("clock test done");
		repeat (2) begin
			hook = ~hook;
			wt(8'h00, 3300);
			`CHK(irq, 1'b1)
			acc(0, `HBI_REG_CAUSE, 8'h00);
			`CHK(rd, 8'h01)
			repeat (5) @(posedge clk);
			#2;
			`CHK(irq, 1'b0)
		end
		$display("hook test done");
		acc(0, 3'h6, 8'h00);
		`CHK(rd, 8'h00)
		acc(1, `HBI_REG_CTRL, 8'h01);
		acc(0, `HBI_REG_STAT, 8'h00);
		`CHK(rd[`HBI_STAT_MODE], 1'b1)
		`CHK(rd[`HBI_STAT_HOOK], hook)
		acc(0, `HBI_REG_CAUSE, 8'h00);
		`CHK(rd[`HBI_CAUSE_ACT], 1'b1)
		repeat (4) @(posedge clk);
		#2;
		`CHK(active_mode, 1'b1)
		reset = 1;
		#5;
		`CHK(active_mode, 1'b0)
		`CHK(ctrl_out, `HBI_CTRL_RST)
		repeat (2) @(posedge clk);
		#2;
		reset = 0;
		acc(0, `HBI_REG_MASK, 8'h00);
		`CHK(rd, `HBI_MASK_RST)
		$display("reset test done");
		end_of_test();
	end
endmodule : test_host_bus_interface
